// file: verilog/dtx_link_tx.sv
`timescale 1ns/1ns
// Summary of operation
// - sysref restarts and realigns multiframe counter
// - single 0x8000 sample, msb on pin
// - short test pattern f1 downward each frame
// - long sync request sets bit 4, interrupt
// - F=8 link tick twice frame tick
// - above 12200 Mbps select soft coding sublayer
// - no error bit except resync ever set
// - alignment multiframes start 1c, end 7c
// - comma held one frame plus nine octets
module dtx_link_tx
  import dtx_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 sysref_pin,
  input  wire logic                 sync_n_pin,
  input  wire logic [1:0]           f_sel,
  input  wire logic [1:0]           src_sel,
  input  wire logic                 pulse_req,
  input  wire logic                 err_clear_wr,
  input  wire logic [ERR_WIDTH-1:0] err_clear_data,
  input  wire logic [15:0]          lane_rate_mbps,
  output logic      [7:0]           tx_octet,
  output logic                      tx_kchar,
  output logic                      lmfc_edge,
  output logic                      link_tick,
  output logic                      frame_tick,
  output logic                      latency_pin,
  output logic                      soft_pcs_sel,
  output logic      [ERR_WIDTH-1:0] tx_err_status,
  output logic                      tx_link_interrupt
);
  // ==========================================================
  // reset release and pin synchronisers
  logic       rst_s1;
  logic       rst_n;
  logic [1:0] pins_level;
  logic       sysref_lvl;
  logic       sync_lvl;
  logic       sysref_prev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  dtx_pin_sync #(.WIDTH(2)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({sysref_pin, sync_n_pin}),
    .level (pins_level)
  );
  assign sysref_lvl = pins_level[1];
  assign sync_lvl   = pins_level[0];

  // ==========================================================
  // helpers
  function automatic logic [7:0] mf_last(input logic [1:0] fs);
    mf_last = 8'((9'(FRAMES_PER_MF) << fs) - 9'h1);
  endfunction

  function automatic logic [5:0] pad_limit(input logic [1:0] fs, input int frames);
    pad_limit = 6'((frames << fs) + PAD_OCTETS);
  endfunction

  // high nibble steps down from f, low nibble up from 1 and wraps to 0 at octet 7
  function automatic logic [7:0] short_octet(input logic [2:0] idx);
    short_octet = {4'(PAT_FIRST[7:4] - {1'b0, idx}), 1'b0, 3'(PAT_FIRST[2:0] + idx)};
  endfunction

  // ==========================================================
  // octet timing and control state
  dtx_state_t     state;
  dtx_state_t     next_state;
  logic [7:0]     oct;
  logic [7:0]     next_oct;
  logic [1:0]     mf_idx;
  logic [1:0]     next_mf_idx;
  logic [5:0]     wait_cnt;
  logic [5:0]     next_wait_cnt;
  logic [1:0]     link_div;
  logic           pulse_pend;
  logic           next_pulse_pend;
  logic           pulse_frame;
  logic           next_pulse_frame;
  logic [7:0]     next_tx_octet;
  logic           next_tx_kchar;
  logic           next_lmfc_edge;
  logic           next_link_tick;
  logic           next_frame_tick;
  logic [ERR_WIDTH-1:0] next_err;
  logic           sysref_rise;
  logic           resync_hit;
  logic [2:0]     fidx;
  logic           oct_last;

  assign sysref_rise = sysref_lvl && !sysref_prev;
  assign fidx        = 3'(oct & ((8'h1 << f_sel) - 8'h1));
  assign oct_last    = (oct == mf_last(f_sel));
  // long sync request only counts once the link was up
  assign resync_hit  = (state != DTX_ST_CGS) && !sync_lvl
                       && (wait_cnt > pad_limit(f_sel, RESYNC_FRAMES));

  always_comb begin
    next_state       = state;
    next_mf_idx      = mf_idx;
    next_wait_cnt    = wait_cnt;
    next_pulse_pend  = pulse_pend || pulse_req;
    next_pulse_frame = pulse_frame;
    next_oct         = oct_last ? 8'h0 : oct + 8'h1;
    if (sysref_rise) begin
      next_oct = 8'h0;
    end
    next_lmfc_edge  = (next_oct == 8'h0);
    next_link_tick  = (link_div == 2'(OCTETS_PER_LINK - 1));
    // frame spans two link words only at eight octets per frame
    next_frame_tick = next_link_tick
                      && ((f_sel != FSEL_F8) || oct[2]);
    next_tx_octet   = CHR_COMMA;
    next_tx_kchar   = 1'b1;
    unique case (state)
      DTX_ST_CGS: begin
        next_wait_cnt = !sync_lvl ? 6'h0 :
                        (&wait_cnt ? wait_cnt : wait_cnt + 6'h1);
        if (sync_lvl && (wait_cnt >= pad_limit(f_sel, CGS_FRAMES))
            && (next_oct == 8'h0)) begin
          next_state    = DTX_ST_ILAS;
          next_mf_idx   = 2'h0;
          next_wait_cnt = 6'h0;
        end
      end
      DTX_ST_ILAS: begin
        next_tx_kchar = 1'b0;
        next_tx_octet = oct;
        if (oct == 8'h0) begin
          next_tx_octet = CHR_MF_START;
          next_tx_kchar = 1'b1;
        end else if (oct_last) begin
          next_tx_octet = CHR_MF_END;
          next_tx_kchar = 1'b1;
        end else if ((mf_idx == 2'h1) && (oct == 8'h1)) begin
          next_tx_octet = CHR_CFG_START;
          next_tx_kchar = 1'b1;
        end
        if (oct_last) begin
          next_mf_idx = mf_idx + 2'h1;
          if (mf_idx == 2'(ILAS_MF_COUNT - 1)) begin
            next_state = DTX_ST_DATA;
          end
        end
      end
      DTX_ST_DATA: begin
        next_tx_kchar = 1'b0;
        next_tx_octet = 8'h0;
        if (fidx == 3'h0) begin
          next_pulse_frame = (src_sel == DTX_SRC_PULSE) && next_pulse_pend;
          if (next_pulse_frame) begin
            next_pulse_pend = 1'b0;
          end
        end
        if (src_sel == DTX_SRC_SHORT) begin
          next_tx_octet = short_octet(fidx);
        end else if (next_pulse_frame) begin
          next_tx_octet = (fidx == 3'h0) ? PULSE_SAMPLE[15:8] :
                          (fidx == 3'h1) ? PULSE_SAMPLE[7:0] : 8'h0;
        end
      end
    endcase
    if (state != DTX_ST_CGS) begin
      next_wait_cnt = sync_lvl ? 6'h0 :
                      (&wait_cnt ? wait_cnt : wait_cnt + 6'h1);
      if (resync_hit) begin
        next_state       = DTX_ST_CGS;
        next_wait_cnt    = 6'h0;
        next_pulse_frame = 1'b0;
      end
    end
    // clear first, then set, so a same-cycle event wins
    next_err = tx_err_status;
    if (err_clear_wr) begin
      next_err = next_err & ~err_clear_data;
    end
    if (resync_hit) begin
      next_err[ERR_RESYNC_BIT] = 1'b1;
    end
    next_err = next_err & ERR_WIDTH'(1 << ERR_RESYNC_BIT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= DTX_ST_CGS;
      oct               <= 8'h0;
      mf_idx            <= 2'h0;
      wait_cnt          <= 6'h0;
      link_div          <= 2'h0;
      sysref_prev       <= 1'b0;
      pulse_pend        <= 1'b0;
      pulse_frame       <= 1'b0;
      tx_octet          <= CHR_COMMA;
      tx_kchar          <= 1'b1;
      lmfc_edge         <= 1'b0;
      link_tick         <= 1'b0;
      frame_tick        <= 1'b0;
      latency_pin       <= 1'b0;
      soft_pcs_sel      <= 1'b0;
      tx_err_status     <= '0;
      tx_link_interrupt <= 1'b0;
    end else begin
      state             <= next_state;
      oct               <= next_oct;
      mf_idx            <= next_mf_idx;
      wait_cnt          <= next_wait_cnt;
      link_div          <= next_link_tick ? 2'h0 : link_div + 2'h1;
      sysref_prev       <= sysref_lvl;
      pulse_pend        <= next_pulse_pend;
      pulse_frame       <= next_pulse_frame;
      tx_octet          <= next_tx_octet;
      tx_kchar          <= next_tx_kchar;
      lmfc_edge         <= next_lmfc_edge;
      link_tick         <= next_link_tick;
      frame_tick        <= next_frame_tick;
      latency_pin       <= next_pulse_frame && (state == DTX_ST_DATA);
      soft_pcs_sel      <= (lane_rate_mbps > SOFT_PCS_MBPS);
      tx_err_status     <= next_err;
      tx_link_interrupt <= |next_err;
    end
  end

  // ==========================================================
  // checks
  chk_sysref_restart: assert property (@(posedge clk) disable iff (!rst_n)
    sysref_rise |=> (oct == 8'h0) && lmfc_edge)
    else $error("multiframe counter not restarted by sysref");
  chk_resync_flag: assert property (@(posedge clk) disable iff (!rst_n)
    resync_hit |=> tx_err_status[ERR_RESYNC_BIT] && tx_link_interrupt)
    else $error("resync flag or interrupt missing");
  chk_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    tx_link_interrupt == (|tx_err_status))
    else $error("interrupt disagrees with error status");
  chk_w1c_clear: assert property (@(posedge clk) disable iff (!rst_n)
    err_clear_wr && err_clear_data[ERR_RESYNC_BIT] && !resync_hit
    |=> !tx_err_status[ERR_RESYNC_BIT])
    else $error("write one did not clear resync flag");
  chk_other_bits: assert property (@(posedge clk) disable iff (!rst_n)
    tx_err_status[ERR_RESYNC_BIT-1:0] == '0)
    else $error("unexpected error bit set");
  chk_ilas_markers: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DTX_ST_ILAS) && oct_last |=> tx_kchar && (tx_octet == CHR_MF_END))
    else $error("multiframe end marker missing");
  chk_comma_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DTX_ST_CGS) && (next_state == DTX_ST_ILAS)
    |-> sync_lvl && (wait_cnt >= pad_limit(f_sel, CGS_FRAMES)))
    else $error("alignment began before comma hold time");
  chk_short_first: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DTX_ST_DATA) && (src_sel == DTX_SRC_SHORT) && (fidx == 3'h0)
    && !resync_hit |=> (tx_octet == PAT_FIRST) && !tx_kchar)
    else $error("short pattern does not start at f1");
  chk_pulse_msb: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(latency_pin) |-> (tx_octet == PULSE_SAMPLE[15:8]))
    else $error("latency pin not aligned with sample msb");
  cov_reach_data: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(state == DTX_ST_DATA));
  cov_resync: cover property (@(posedge clk) disable iff (!rst_n) resync_hit);
  cov_pulse: cover property (@(posedge clk) disable iff (!rst_n) $rose(latency_pin));
  cov_sysref_mid: cover property (@(posedge clk) disable iff (!rst_n)
    sysref_rise && (oct != 8'h0));
endmodule

// file: verilog/dtx_pkg.sv
package dtx_pkg;
  // ==========================================================
  // link framing
  localparam int          FRAMES_PER_MF   = 32;
  localparam int          ILAS_MF_COUNT   = 4;
  localparam int          CGS_FRAMES      = 1;
  localparam int          RESYNC_FRAMES   = 5;
  localparam int          PAD_OCTETS      = 9;
  localparam int          OCTETS_PER_LINK = 4;
  // ==========================================================
  // control characters (with k flag set)
  localparam logic [7:0]  CHR_COMMA       = 8'hbc;
  localparam logic [7:0]  CHR_MF_START    = 8'h1c;
  localparam logic [7:0]  CHR_MF_END      = 8'h7c;
  localparam logic [7:0]  CHR_CFG_START   = 8'h9c;
  // ==========================================================
  // test patterns and soft coding rate threshold
  localparam logic [7:0]  PAT_FIRST       = 8'hf1;
  localparam logic [15:0] PULSE_SAMPLE    = 16'h8000;
  localparam logic [15:0] SOFT_PCS_MBPS   = 16'h2fa8;  // 12200
  // ==========================================================
  // octets-per-frame select, F = 1 << f_sel
  localparam logic [1:0]  FSEL_F8         = 2'h3;
  // data source select
  typedef enum logic [1:0] {
    DTX_SRC_USER  = 2'h0,
    DTX_SRC_SHORT = 2'h1,
    DTX_SRC_PULSE = 2'h2
  } dtx_src_t;
  localparam int          ERR_RESYNC_BIT  = 4;
  localparam int          ERR_WIDTH       = 5;
  typedef enum logic [2:0] {
    DTX_ST_CGS  = 3'b001,
    DTX_ST_ILAS = 3'b010,
    DTX_ST_DATA = 3'b100
  } dtx_state_t;
endpackage

// file: verilog/dtx_pin_sync.sv
`timescale 1ns/1ns
module dtx_pin_sync
  import dtx_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  // ==========================================================
  // three stages; a change counts once stages two and three agree
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      level <= '0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule

// file: tb/dtx_dac_model.sv
`timescale 1ns/1ns
module dtx_dac_model
  import dtx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       hold_sync,
  input  wire logic       sys_en,
  input  wire logic [1:0] f_sel,
  output logic            sysref_pin,
  output logic            sync_n_pin
);
  // ==========================================================
  // clock source and receiver side
  int cnt;
  int per;
  // the eight-octet mode only settles with one multiframe spacing
  assign per = (f_sel == FSEL_F8) ? FRAMES_PER_MF * 8
             : 2 * FRAMES_PER_MF * (1 << f_sel);
  always @(posedge clk) begin
    cnt <= (!sys_en || cnt >= per - 1) ? 0 : cnt + 1;
    sysref_pin <= sys_en && cnt < 2;
    sync_n_pin <= !hold_sync;
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
module tb
  import dtx_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic                 clk = 1'b0, resetn = 1'b0, hold_sync = 1'b1, sys_en = 1'b0;
  logic [1:0]           f_sel = 2'h0, src_sel = 2'h1;
  logic                 pulse_req = 1'b0, err_clear_wr = 1'b0;
  logic [ERR_WIDTH-1:0] err_clear_data = 5'h00, tx_err_status;
  logic [15:0]          lane_rate_mbps = 16'h2fa8;
  logic [7:0]           tx_octet;
  logic                 sysref_pin, sync_n_pin, tx_kchar, lmfc_edge, link_tick;
  logic                 frame_tick, latency_pin, soft_pcs_sel, tx_link_interrupt;
  int                   error_cnt = 0, checked = 0, fb, mf, n, idx;
  // short test octets, first octet in the top byte
  localparam logic [63:0] SHORT_PAT = 64'hf1e2d3c4b5a69780;

  always #10 clk = ~clk;

  dtx_dac_model dac (.clk(clk), .hold_sync(hold_sync), .sys_en(sys_en), .f_sel(f_sel),
    .sysref_pin(sysref_pin), .sync_n_pin(sync_n_pin));

  dtx_link_tx uut (.clk(clk), .resetn(resetn), .sysref_pin(sysref_pin),
    .sync_n_pin(sync_n_pin), .f_sel(f_sel), .src_sel(src_sel), .pulse_req(pulse_req),
    .err_clear_wr(err_clear_wr), .err_clear_data(err_clear_data),
    .lane_rate_mbps(lane_rate_mbps), .tx_octet(tx_octet), .tx_kchar(tx_kchar),
    .lmfc_edge(lmfc_edge), .link_tick(link_tick), .frame_tick(frame_tick),
    .latency_pin(latency_pin), .soft_pcs_sel(soft_pcs_sel),
    .tx_err_status(tx_err_status), .tx_link_interrupt(tx_link_interrupt));

  // ==========================================================
  // reporting
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_oct(input logic k, input logic [7:0] o);
    chk({7'h00, tx_kchar, tx_octet}, {7'h00, k, o});
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  // a wait that ran out of its bound ends the run
  task automatic stuck(input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, n, lim);
      complete_run();
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic link_up();
    src_sel = 2'h1;
    for (n = 0; n < 40 * fb + 60 && tx_octet !== CHR_MF_START; n++) begin
      chk_oct(1'b1, CHR_COMMA);
      tick(1);
    end
    stuck(40 * fb + 60);
    chk(16'(n >= fb + PAD_OCTETS), 16'h0001);
    for (n = 0; n < ILAS_MF_COUNT * mf; n++) begin
      idx = n % mf;
      if (idx == 0) chk_oct(1'b1, CHR_MF_START);
      else if (idx == mf - 1) chk_oct(1'b1, CHR_MF_END);
      else if (n / mf == 1 && idx == 1) chk_oct(1'b1, CHR_CFG_START);
      else chk_oct(1'b0, idx[7:0]);
      // boundary flag marks counter index 0, one cycle ahead of its octet
      chk(16'(lmfc_edge), 16'(idx == mf - 1));
      tick(1);
    end
    for (n = 0; n < 4 * fb; n++) begin
      chk_oct(1'b0, SHORT_PAT[8 * (7 - n % fb) +: 8]);
      tick(1);
    end
    chk({10'h000, tx_link_interrupt, tx_err_status}, 16'h0000);
  endtask

  task automatic bring_up(input logic [1:0] f);
    f_sel = f;
    fb = 1 << f;
    mf = FRAMES_PER_MF * fb;
    hold_sync = 1'b1;
    resetn = 1'b0;
    tick(5);
    chk_oct(1'b1, CHR_COMMA);
    chk({5'h00, lmfc_edge, link_tick, frame_tick, latency_pin, soft_pcs_sel,
         tx_link_interrupt, tx_err_status}, 16'h0000);
    resetn = 1'b1;
    tick(40);
    hold_sync = 1'b0;
    link_up();
    idx = 0;
    n = 0;
    repeat (32) begin
      idx += link_tick;
      n += frame_tick;
      tick(1);
    end
    chk(16'(idx), 16'h0008);
    chk(16'(n), (f == FSEL_F8) ? 16'h0004 : 16'h0008);
  endtask

  task automatic pulse_case();
    src_sel = 2'h2;
    pulse_req = 1'b1;
    tick(1);
    pulse_req = 1'b0;
    for (n = 0; n < 4 * fb + 8 && latency_pin !== 1'b1; n++) tick(1);
    stuck(4 * fb + 8);
    chk_oct(1'b0, PULSE_SAMPLE[15:8]);
    tick(1);
    chk_oct(1'b0, PULSE_SAMPLE[7:0]);
    for (n = 1; n < 6 * fb && latency_pin === 1'b1; n++) tick(1);
    chk(16'(n), 16'(fb));
    repeat (4 * fb) begin
      chk({7'h00, latency_pin, tx_octet}, 16'h0000);
      tick(1);
    end
  endtask

  task automatic resync_case();
    // a drop shorter than the limit leaves the link alone
    hold_sync = 1'b1;
    tick(RESYNC_FRAMES * fb);
    hold_sync = 1'b0;
    tick(5 * fb + 30);
    chk({11'h000, tx_err_status}, 16'h0000);
    hold_sync = 1'b1;
    for (n = 0; n < 5 * fb + 30 && tx_err_status[ERR_RESYNC_BIT] !== 1'b1; n++) tick(1);
    stuck(5 * fb + 30);
    chk(16'(n > 5 * fb + PAD_OCTETS), 16'h0001);
    chk({10'h000, tx_link_interrupt, tx_err_status}, 16'h0030);
    tick(1);
    chk_oct(1'b1, CHR_COMMA);
    hold_sync = 1'b0;
    err_clear_wr = 1'b1;
    err_clear_data = 5'h0f;
    tick(1);
    chk({10'h000, tx_link_interrupt, tx_err_status}, 16'h0030);
    err_clear_data = 5'h10;
    tick(1);
    err_clear_wr = 1'b0;
    chk({10'h000, tx_link_interrupt, tx_err_status}, 16'h0000);
    link_up();
  endtask

  task automatic sysref_case();
    sys_en = 1'b1;
    for (n = 0; n < 2 * mf + 8 && sysref_pin !== 1'b1; n++) tick(1);
    stuck(2 * mf + 8);
    // a natural boundary may precede the restart, so keep the last one
    idx = -1;
    for (n = 0; n < 8; n++) begin
      if (lmfc_edge === 1'b1) idx = n;
      tick(1);
    end
    chk(16'(idx >= 0), 16'h0001);
    for (n = 8; n < 8 + 2 * mf && lmfc_edge !== 1'b1; n++) tick(1);
    chk(16'(n - idx), 16'(mf));
    sys_en = 1'b0;
  endtask

  task automatic pcs_case();
    lane_rate_mbps = SOFT_PCS_MBPS;
    src_sel = DTX_SRC_USER;
    tick(2);
    chk(16'(soft_pcs_sel), 16'h0000);
    // user source sends zero octets
    chk_oct(1'b0, 8'h00);
    lane_rate_mbps = SOFT_PCS_MBPS + 16'h0001;
    tick(2);
    chk(16'(soft_pcs_sel), 16'h0001);
  endtask

  initial begin
    for (int f = 0; f < 4; f++) bring_up(2'(f));
    pulse_case();
    resync_case();
    sysref_case();
    pcs_case();
    complete_run();
  end
endmodule
